// *** logic/channel_power_control_status.sv ***
// Purpose: Channel power-up/down control, feature enables and power status
// Assumes: Register port driven by the control-port front end on clk_sys
// Notes:   Status bits set on completed power-up, clear as soon as power-down starts
`timescale 1ns/1ps
`include "chpwr_regs.svh"

// Overview of operation
// - Record dynamic bit low: input enable changes refused while any input is not fully off.
// - Playback dynamic bit low: output enable changes refused while any output is not fully off.
// - Record count select: dynamic changes on inputs 1-2 only, or 1-4.
// - Playback count select: dynamic changes on outputs 1-2 only, or 1-4.
// - Bit 3 selects same or split modulator and mic clocks during dynamic power.
// - Record swap bit exchanges record channels 1 and 2.
// - Playback swap bit exchanges playback channels 1 and 2.
// - Record power bit off powers down all inputs; on powers enabled inputs.
// - Playback power bit off powers down all outputs; on powers enabled outputs.
// - Microphone bias generator follows its power bit.
// - Power bit 3 enables ultrasound activity detection.
// - Power bit 2 enables voice activity detection.
// - Power bit 1 enables ultrasound generation.
// - Status bits 7..4 show inputs 1..4 powered state.
// - Status bits 3..0 show outputs 1..4 powered state.
// - Channel enable register, one bit per channel, resets to 0xcc.
module channel_power_control_status
	import chpwr_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// Channel power requests to analog and PDM front ends
	output logic      [3:0] in_power_req,
	output logic      [3:0] out_power_req,
	// Routing and clocking controls
	output logic            record_pair_swap,
	output logic            playback_pair_swap,
	output logic            dynamic_split_mic_clocks,
	// Feature enables
	output logic            microphone_bias_power_on,
	output logic            ultrasound_detect_enable,
	output logic            voice_detect_enable,
	output logic            ultrasound_generate_enable
);

	// ======================================================================
	// Functions
	function automatic logic change_allowed(input int idx, input logic busy,
		input logic dyn_en, input logic all_four);
		logic ok;
		ok = 1'b1;
		if (busy) begin
			ok = dyn_en && ((idx % 4) < 2 || all_four);
		end
		return ok;
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction

	// ======================================================================
	// Declarations
	logic        [7:0] channel_enable_bits_r;
	logic        [7:0] dyn_cfg_r;
	logic        [7:0] power_config_r;
	logic        [7:0] applied_r;
	logic        [7:0] req_r;
	logic        [7:0] target;
	logic        [7:0] powered;
	logic        [7:0] status;
	logic              rec_busy;
	logic              play_busy;
	chan_state_t       st_r  [8];
	ramp_cnt_t         cnt_r [8];
	logic        [7:0] reg_rdata_r;
	logic              reg_rvalid_r;

	// ======================================================================
	// Configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			channel_enable_bits_r <= `RST_CHANNEL_ENABLE_BITS;
		end else if (reg_wr && addr_hit(reg_addr, `ADDR_CHANNEL_ENABLE_BITS)) begin
			channel_enable_bits_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dyn_cfg_r <= `RST_DYN_CFG;
		end else if (reg_wr && addr_hit(reg_addr, `ADDR_DYN_CFG)) begin
			dyn_cfg_r <= reg_wdata & `DYN_WMASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_config_r <= `RST_POWER_CONFIG;
		end else if (reg_wr && addr_hit(reg_addr, `ADDR_POWER_CONFIG)) begin
			power_config_r <= reg_wdata & `PWR_WMASK;
		end
	end

	// ======================================================================
	// Direct control outputs
	assign record_pair_swap           = dyn_cfg_r[`DYN_REC_SWAP];
	assign playback_pair_swap         = dyn_cfg_r[`DYN_PLAY_SWAP];
	assign dynamic_split_mic_clocks   = dyn_cfg_r[`DYN_SPLIT_CLK];
	assign microphone_bias_power_on   = power_config_r[`PWR_BIAS_ON];
	assign ultrasound_detect_enable   = power_config_r[`PWR_ULTRASOUND_DETECT_ENABLE];
	assign voice_detect_enable        = power_config_r[`PWR_VOICE_DETECT_ENABLE];
	assign ultrasound_generate_enable = power_config_r[`PWR_ULTRASOUND_GENERATE_ENABLE];

	// ======================================================================
	// Channel activity
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			powered[i] = (st_r[i] == CH_ON);
		end
	end

	always_comb begin
		rec_busy  = 1'b0;
		play_busy = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rec_busy  = rec_busy  | (st_r[i] != CH_OFF);
			play_busy = play_busy | (st_r[i + 4] != CH_OFF);
		end
	end

	// ======================================================================
	// Applied enable mask: gated by dynamic power settings
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			applied_r <= `RST_APPLIED;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (change_allowed(i, rec_busy, dyn_cfg_r[`DYN_REC_EN],
					dyn_cfg_r[`DYN_REC_CNT])) begin
					applied_r[i] <= channel_enable_bits_r[7 - i];
				end
				if (change_allowed(i, play_busy, dyn_cfg_r[`DYN_PLAY_EN],
					dyn_cfg_r[`DYN_PLAY_CNT])) begin
					applied_r[i + 4] <= channel_enable_bits_r[3 - i];
				end
			end
		end
	end

	// Global power gates all channels of a path
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			target[i]     = power_config_r[`PWR_REC_ON] & applied_r[i];
			target[i + 4] = power_config_r[`PWR_PLAY_ON] & applied_r[i + 4];
		end
	end

	// ======================================================================
	// Per-channel power sequencing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				st_r[i]  <= CH_OFF;
				cnt_r[i] <= '0;
				req_r[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				case (st_r[i])
					CH_OFF: begin
						if (target[i]) begin
							st_r[i]  <= CH_RAMP_UP;
							req_r[i] <= 1'b1;
							if (i < 4 && dyn_cfg_r[`DYN_SPLIT_CLK]) begin
								cnt_r[i] <= ramp_cnt_t'(`RAMP_UP_SPLIT_CYC - 1);
							end else begin
								cnt_r[i] <= ramp_cnt_t'(`RAMP_UP_CYC - 1);
							end
						end
					end
					CH_RAMP_UP: begin
						if (!target[i]) begin
							st_r[i]  <= CH_RAMP_DOWN;
							req_r[i] <= 1'b0;
							cnt_r[i] <= ramp_cnt_t'(`RAMP_DOWN_CYC - 1);
						end else if (cnt_r[i] == '0) begin
							st_r[i] <= CH_ON;
						end else begin
							cnt_r[i] <= cnt_r[i] - 1'b1;
						end
					end
					CH_ON: begin
						if (!target[i]) begin
							st_r[i]  <= CH_RAMP_DOWN;
							req_r[i] <= 1'b0;
							cnt_r[i] <= ramp_cnt_t'(`RAMP_DOWN_CYC - 1);
						end
					end
					CH_RAMP_DOWN: begin
						if (cnt_r[i] == '0) begin
							st_r[i] <= CH_OFF;
						end else begin
							cnt_r[i] <= cnt_r[i] - 1'b1;
						end
					end
					default: begin
						st_r[i]  <= CH_OFF;
						req_r[i] <= 1'b0;
					end
				endcase
			end
		end
	end

	assign in_power_req  = req_r[3:0];
	assign out_power_req = req_r[7:4];

	// ======================================================================
	// Status and read-back
	assign status = {powered[0], powered[1], powered[2], powered[3],
		powered[4], powered[5], powered[6], powered[7]};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_CHANNEL_ENABLE_BITS:   reg_rdata_r <= channel_enable_bits_r;
				`ADDR_DYN_CFG: reg_rdata_r <= dyn_cfg_r;
				`ADDR_POWER_CONFIG: reg_rdata_r <= power_config_r;
				`ADDR_PWR_STS: reg_rdata_r <= status;
				default:       reg_rdata_r <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd;
		end
	end

	assign reg_rdata  = reg_rdata_r;
	assign reg_rvalid = reg_rvalid_r;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_rec_frozen;
		rec_busy && !dyn_cfg_r[`DYN_REC_EN] |=> applied_r[3:0] == $past(applied_r[3:0]);
	endproperty
	a_rec_frozen: assert property (p_rec_frozen) else $error("input mask changed");

	property p_play_frozen;
		play_busy && !dyn_cfg_r[`DYN_PLAY_EN] |=> applied_r[7:4] == $past(applied_r[7:4]);
	endproperty
	a_play_frozen: assert property (p_play_frozen) else $error("output mask changed");

	property p_rec_pair_only;
		rec_busy && !dyn_cfg_r[`DYN_REC_CNT] |=> applied_r[3:2] == $past(applied_r[3:2]);
	endproperty
	a_rec_pair_only: assert property (p_rec_pair_only) else $error("input 3/4 changed");

	property p_play_pair_only;
		play_busy && !dyn_cfg_r[`DYN_PLAY_CNT] |=> applied_r[7:6] == $past(applied_r[7:6]);
	endproperty
	a_play_pair_only: assert property (p_play_pair_only) else $error("output 3/4 changed");

	property p_rec_off;
		!power_config_r[`PWR_REC_ON] |=> in_power_req == 4'h0;
	endproperty
	a_rec_off: assert property (p_rec_off) else $error("input powered while off");

	property p_play_off;
		!power_config_r[`PWR_PLAY_ON] |=> out_power_req == 4'h0;
	endproperty
	a_play_off: assert property (p_play_off) else $error("output powered while off");

	property p_bias_write;
		reg_wr && reg_addr == `ADDR_POWER_CONFIG |=> microphone_bias_power_on == $past(reg_wdata[5]);
	endproperty
	a_bias_write: assert property (p_bias_write) else $error("bias not updated");

	property p_status_read;
		reg_rd && reg_addr == `ADDR_PWR_STS |=> reg_rvalid && reg_rdata == $past(status);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	property p_reserved_zero;
		reg_rd && reg_addr == `ADDR_POWER_CONFIG |=> reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_chen_write;
		reg_wr && reg_addr == `ADDR_CHANNEL_ENABLE_BITS |=> channel_enable_bits_r == $past(reg_wdata);
	endproperty
	a_chen_write: assert property (p_chen_write) else $error("enable not stored");

	property p_rec_swap;
		reg_wr && reg_addr == `ADDR_DYN_CFG |=> record_pair_swap == $past(reg_wdata[1]);
	endproperty
	a_rec_swap: assert property (p_rec_swap) else $error("record swap not updated");

	property p_play_swap;
		reg_wr && reg_addr == `ADDR_DYN_CFG |=> playback_pair_swap == $past(reg_wdata[0]);
	endproperty
	a_play_swap: assert property (p_play_swap) else $error("playback swap not updated");

	property p_feature_write;
		reg_wr && reg_addr == `ADDR_POWER_CONFIG |=> {ultrasound_detect_enable, voice_detect_enable,
			ultrasound_generate_enable} == $past(reg_wdata[3:1]);
	endproperty
	a_feature_write: assert property (p_feature_write) else $error("feature bits wrong");

	property p_split_ramp;
		st_r[1] == CH_OFF && target[1] && dyn_cfg_r[`DYN_SPLIT_CLK]
			|=> cnt_r[1] == ramp_cnt_t'(`RAMP_UP_SPLIT_CYC - 1);
	endproperty
	a_split_ramp: assert property (p_split_ramp) else $error("split ramp length wrong");

	property p_up_request;
		st_r[1] == CH_OFF && target[1] |=> in_power_req[1];
	endproperty
	a_up_request: assert property (p_up_request) else $error("power request missing");

	sequence s_up_start;
		st_r[0] == CH_OFF ##1 st_r[0] == CH_RAMP_UP;
	endsequence
	sequence s_status_low;
		(!status[7])[*8];
	endsequence
	property p_status_late;
		s_up_start |-> s_status_low;
	endproperty
	a_status_late: assert property (p_status_late) else $error("status rose early");

endmodule

// *** logic/chpwr_regs.svh ***
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes:   Included by the channel power control block
`ifndef CHPWR_REGS_SVH
`define CHPWR_REGS_SVH

// ==========================================================================
// Register offsets
`define ADDR_CHANNEL_ENABLE_BITS          8'h76
`define ADDR_DYN_CFG        8'h77
`define ADDR_POWER_CONFIG        8'h78
`define ADDR_PWR_STS        8'h79

// ==========================================================================
// Reset values
`define RST_CHANNEL_ENABLE_BITS           8'hcc
`define RST_DYN_CFG         8'h00
`define RST_POWER_CONFIG         8'h00
`define RST_APPLIED         8'h33

// ==========================================================================
// Writable bits (reserved bits masked)
`define DYN_WMASK           8'hfb
`define PWR_WMASK           8'hee

// ==========================================================================
// Field positions
`define DYN_REC_EN          7
`define DYN_REC_CNT         6
`define DYN_PLAY_EN         5
`define DYN_PLAY_CNT        4
`define DYN_SPLIT_CLK       3
`define DYN_REC_SWAP        1
`define DYN_PLAY_SWAP       0
`define PWR_REC_ON          7
`define PWR_PLAY_ON         6
`define PWR_BIAS_ON         5
`define PWR_ULTRASOUND_DETECT_ENABLE          3
`define PWR_VOICE_DETECT_ENABLE          2
`define PWR_ULTRASOUND_GENERATE_ENABLE          1

// ==========================================================================
// Timing
`define CLK_FREQ_MHZ        100
`define PWR_UP_TIME_NS      2000
`define PWR_UP_SPLIT_NS     4000
`define PWR_DOWN_TIME_NS    1000
`define RAMP_UP_CYC         ((`PWR_UP_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RAMP_UP_SPLIT_CYC   ((`PWR_UP_SPLIT_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define RAMP_DOWN_CYC       ((`PWR_DOWN_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

// *** logic/chpwr_pkg.sv ***
// Purpose: Types for the channel power control block
// Assumes: Nothing beyond the register header
// Notes:   Channel index 0..3 are inputs 1..4, 4..7 outputs 1..4
package chpwr_pkg;

	// ======================================================================
	// Channel power state
	typedef enum logic [1:0] {
		CH_OFF,
		CH_RAMP_UP,
		CH_ON,
		CH_RAMP_DOWN
	} chan_state_t;

	typedef logic [9:0] ramp_cnt_t;

endpackage

// *** dv/channel_power_control_status_bench.sv ***
// Purpose: Self-checking bench for the channel power control block
// Assumes: Register strobes sampled on the rising edge, read data one cycle later
// Notes:   Driver queues read results, a monitor checks them
`timescale 1ns/1ps
`include "chpwr_regs.svh"

module channel_power_control_status_bench
	import chpwr_pkg::*;
();

	// ======================================================================
	// Signals
	logic       clk_sys;
	logic       rst_n;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [3:0] in_power_req;
	logic [3:0] out_power_req;
	logic       record_pair_swap;
	logic       playback_pair_swap;
	logic       dynamic_split_mic_clocks;
	logic       microphone_bias_power_on;
	logic       ultrasound_detect_enable;
	logic       voice_detect_enable;
	logic       ultrasound_generate_enable;
	logic [6:0] ctl_out;
	logic [7:0] exp_q[$];
	logic [7:0] wv;
	logic [7:0] pv;
	int         mismatches = 0;
	int         check_count = 0;
	int         seed = 1;

	assign ctl_out = {record_pair_swap, playback_pair_swap, dynamic_split_mic_clocks,
		microphone_bias_power_on, ultrasound_detect_enable, voice_detect_enable,
		ultrasound_generate_enable};

	// ======================================================================
	// Device
	channel_power_control_status dut (
		.clk_sys                    (clk_sys),
		.rst_n                      (rst_n),
		.reg_addr                   (reg_addr),
		.reg_wr                     (reg_wr),
		.reg_wdata                  (reg_wdata),
		.reg_rd                     (reg_rd),
		.reg_rdata                  (reg_rdata),
		.reg_rvalid                 (reg_rvalid),
		.in_power_req               (in_power_req),
		.out_power_req              (out_power_req),
		.record_pair_swap           (record_pair_swap),
		.playback_pair_swap         (playback_pair_swap),
		.dynamic_split_mic_clocks   (dynamic_split_mic_clocks),
		.microphone_bias_power_on   (microphone_bias_power_on),
		.ultrasound_detect_enable   (ultrasound_detect_enable),
		.voice_detect_enable        (voice_detect_enable),
		.ultrasound_generate_enable (ultrasound_generate_enable)
	);

	// ======================================================================
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		cyc(1);
		reg_wr    = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd   = 1'b1;
		exp_q.push_back(e);
		cyc(1);
		reg_rd   = 1'b0;
		cyc(1);
	endtask

	task automatic preq(input logic [3:0] i, input logic [3:0] o);
		cyc(1);
		check({in_power_req, out_power_req}, {i, o});
	endtask

	task automatic report_and_stop();
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ======================================================================
	// Clock and read monitor
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(negedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() > 0) begin
				check(reg_rdata, exp_q.pop_front());
			end else begin
				check(reg_rdata, 8'hxx);
			end
		end
	end

	// ======================================================================
	// Stimulus
	initial begin
		rst_n     = 1'b0;
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
		reg_rd    = 1'b0;
		cyc(5);
		rst_n = 1'b1;
		cyc(1);
		rd(`ADDR_CHANNEL_ENABLE_BITS, 8'hcc);
		rd(`ADDR_DYN_CFG, 8'h00);
		rd(`ADDR_POWER_CONFIG, 8'h00);
		rd(`ADDR_PWR_STS, 8'h00);
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00);
		// Random field values, record and playback power bits held off
		for (int i = 0; i < 8; i++) begin
			wv = $random(seed) & 8'hfb;
			pv = $random(seed) & 8'h2e;
			wr(`ADDR_DYN_CFG, wv);
			wr(`ADDR_POWER_CONFIG, pv);
			check({1'b0, ctl_out}, {1'b0, wv[1], wv[0], wv[3], pv[5], pv[3:1]});
			rd(`ADDR_DYN_CFG, wv & 8'hfb);
			rd(`ADDR_POWER_CONFIG, pv & 8'hee);
			check({in_power_req, out_power_req}, 8'h00);
		end
		wr(`ADDR_DYN_CFG, 8'h00);
		wr(`ADDR_POWER_CONFIG, 8'h00);
		cyc(2);
		// Inputs on, status follows completed ramp
		wr(`ADDR_POWER_CONFIG, 8'h80);
		preq(4'h3, 4'h0);
		cyc(90);
		rd(`ADDR_PWR_STS, 8'h00);
		cyc(120);
		rd(`ADDR_PWR_STS, 8'hc0);
		// Enable changes while recording
		wr(`ADDR_CHANNEL_ENABLE_BITS, 8'hfc);
		preq(4'h3, 4'h0);
		rd(`ADDR_CHANNEL_ENABLE_BITS, 8'hfc);
		wr(`ADDR_DYN_CFG, 8'h80);
		preq(4'h3, 4'h0);
		wr(`ADDR_DYN_CFG, 8'hc0);
		preq(4'hf, 4'h0);
		wr(`ADDR_CHANNEL_ENABLE_BITS, 8'h7c);
		preq(4'he, 4'h0);
		// Outputs on
		wr(`ADDR_POWER_CONFIG, 8'hc0);
		preq(4'he, 4'h3);
		cyc(210);
		rd(`ADDR_PWR_STS, 8'h7c);
		wr(`ADDR_CHANNEL_ENABLE_BITS, 8'h7f);
		preq(4'he, 4'h3);
		wr(`ADDR_DYN_CFG, 8'he0);
		preq(4'he, 4'h3);
		wr(`ADDR_DYN_CFG, 8'hf0);
		preq(4'he, 4'hf);
		// All off
		wr(`ADDR_POWER_CONFIG, 8'h00);
		preq(4'h0, 4'h0);
		rd(`ADDR_PWR_STS, 8'h00);
		cyc(120);
		// Split clocks lengthen input ramp
		wr(`ADDR_DYN_CFG, 8'h08);
		check({7'h00, dynamic_split_mic_clocks}, 8'h01);
		wr(`ADDR_POWER_CONFIG, 8'h80);
		preq(4'he, 4'h0);
		cyc(300);
		rd(`ADDR_PWR_STS, 8'h00);
		cyc(120);
		rd(`ADDR_PWR_STS, 8'h70);
		wr(`ADDR_PWR_STS, 8'hff);
		rd(`ADDR_PWR_STS, 8'h70);
		// Reset in mid-run with inputs powered
		rst_n = 1'b0;
		cyc(2);
		check({in_power_req, out_power_req}, 8'h00);
		rst_n = 1'b1;
		cyc(1);
		check({1'b0, ctl_out}, 8'h00);
		rd(`ADDR_CHANNEL_ENABLE_BITS, 8'hcc);
		rd(`ADDR_PWR_STS, 8'h00);
		rd(`ADDR_DYN_CFG, 8'h00);
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) begin
			cyc(1);
		end
		if (exp_q.size() > 0) begin
			mismatches++;
		end
		report_and_stop();
	end

endmodule
